// ===== design/ces_sequencer.sv
// Exception acceptance and entry sequencer of the CPU core.
// Assumes the pipeline flags one instruction end per insn_done pulse
// and stalls while cpu_hold is high; memory ports are valid/ready.
// Function
// - Accept pending exceptions by priority: reset, trace, interrupt, trap.
// - Start reset handling when reset input rises or watchdog overflows.
// - Sample non-maskable input at reset: high power-on, low manual reset if manual_en is set, else power-on.
// - With trace flag set, trace after the current instruction ends.
// - Trace exceptions occur only in interrupt control mode 2.
// - No trace after the return-from-exception instruction.
// - Interrupts start only at a completion boundary with a request pending.
// - Skip interrupt detection after reset handling and control-register writes.
// - Trap instruction always raises its exception, unmasked.
// - Trap and interrupt entry push program counter and condition codes; mode 2 also pushes extended flags.
// - After pushing, update mask bits and clear the trace flag.
// - Fetch the source's vector and resume from the fetched address.
// - Reset only updates mask and trace flags and jumps; nothing is pushed.
// - Sources, frame layout and handling follow the control mode bits.
// - Mode code 00 is mode 0, 10 is mode 2; others prohibited.
// - Each source has its own four-byte vector slot from address zero.
// - Reset clears trace flag and sets mask flag in both flag registers.
`timescale 1ns/10ps
module ces_sequencer
	import ces_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        clk_en,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Reset sources
	input  wire logic        reset_in_n,
	input  wire logic        wdt_overflow,
	input  wire logic        nmi_in,
	// Pipeline status
	input  wire logic        insn_done,
	input  wire logic        return_from_exception,
	input  wire logic        and_into_control,
	input  wire logic        or_into_control,
	input  wire logic        xor_into_control,
	input  wire logic        load_control,
	input  wire logic        trap_instruction,
	input  wire logic [1:0]  trap_num,
	input  wire logic [23:0] pc_cur,
	input  wire logic [7:0]  cond_code_cur,
	input  wire logic [7:0]  ext_ctrl_cur,
	input  wire logic [31:0] sp_cur,
	// Pipeline control
	output logic             cpu_hold,
	output logic             pc_load,
	output logic [23:0]      pc_load_val,
	output logic             flags_load,
	output logic [7:0]       cond_code_new,
	output logic [7:0]       ext_ctrl_new,
	output logic [31:0]      sp_new,
	// Interrupt controller
	input  wire logic        irq_req,
	input  wire logic [7:0]  irq_vec_num,
	input  wire logic [2:0]  irq_level,
	output logic             irq_ack,
	// Memory port
	output logic             mem_wr_valid,
	input  wire logic        mem_wr_ready,
	output logic [31:0]      mem_wr_addr,
	output logic [31:0]      mem_wr_data,
	output logic             mem_rd_valid,
	input  wire logic        mem_rd_ready,
	output logic [31:0]      mem_rd_addr,
	input  wire logic [31:0] mem_rd_data
);
	ces_state_type state_q;
	ces_src_type   src_q, src_d;
	logic [7:0]    vec_q, vec_d;
	logic [31:0]   sp_q;
	logic [23:0]   pc_q;
	logic [7:0]    cc_q, ec_q;
	logic [1:0]    push_cnt_q, push_need_q;
	logic          manual_q, trap_pend_q;
	logic [1:0]    trap_num_q;
	logic          mode0_bit, mode1_bit, manual_en;
	logic [1:0]    mode;
	logic          mode2;
	logic          idle_bnd, jump_bnd, ctrl_wr;
	logic          take_trace, take_irq, take_trap, accept;
	logic          reset_go, trap_now;
	logic [31:0]   status;

	// ****
	// Register slave
	// ****
	ces_regs u_regs (
		.clk                (clk),
		.nrst               (nrst),
		.clk_en             (clk_en),
		.s_axi_awaddr       (s_axi_awaddr),
		.s_axi_awvalid      (s_axi_awvalid),
		.s_axi_awready      (s_axi_awready),
		.s_axi_wdata        (s_axi_wdata),
		.s_axi_wstrb        (s_axi_wstrb),
		.s_axi_wvalid       (s_axi_wvalid),
		.s_axi_wready       (s_axi_wready),
		.s_axi_bresp        (s_axi_bresp),
		.s_axi_bvalid       (s_axi_bvalid),
		.s_axi_bready       (s_axi_bready),
		.s_axi_araddr       (s_axi_araddr),
		.s_axi_arvalid      (s_axi_arvalid),
		.s_axi_arready      (s_axi_arready),
		.s_axi_rdata        (s_axi_rdata),
		.s_axi_rresp        (s_axi_rresp),
		.s_axi_rvalid       (s_axi_rvalid),
		.s_axi_rready       (s_axi_rready),
		.mode_clear         (reset_go),
		.status_in          (status),
		.irq_ctrl_mode_bit0 (mode0_bit),
		.irq_ctrl_mode_bit1 (mode1_bit),
		.manual_en          (manual_en)
	);

	assign mode  = {mode1_bit, mode0_bit};
	assign mode2 = ces_is_mode2(mode);

	always_comb begin
		status              = WORD_ZERO;
		status[STS_BUSY]    = cpu_hold;
		status[STS_MANUAL]  = manual_q;
		status[STS_ILLEGAL] = !ces_mode_legal(mode);
		status[STS_TRACE]   = ext_ctrl_cur[T_BIT];
		status[STS_VEC_LSB +: 8] = vec_q;
	end

	// ****
	// Acceptance
	// ****
	assign ctrl_wr  = and_into_control || or_into_control ||
	                  xor_into_control || load_control;
	assign idle_bnd = clk_en && state_q == ST_IDLE && insn_done;
	assign jump_bnd = clk_en && state_q == ST_JUMP;
	assign reset_go = clk_en && (wdt_overflow ||
	                  (state_q == ST_HOLD && reset_in_n));
	assign trap_now = idle_bnd && trap_instruction;

	// Trace: only at an instruction end, since entry clears the flag
	assign take_trace = idle_bnd && ext_ctrl_cur[T_BIT] && mode2 &&
	                    !return_from_exception;
	assign take_irq   = irq_req && ((idle_bnd && !ctrl_wr) ||
	                    (jump_bnd && src_q != SRC_RESET));
	assign take_trap  = trap_now || (jump_bnd && trap_pend_q);
	assign accept     = !reset_go && reset_in_n && (take_trace || take_irq || take_trap);
	assign irq_ack    = accept && !take_trace && take_irq;

	always_comb begin
		src_d = SRC_TRAP;
		vec_d = {VEC_TRAP_HI, trap_now ? trap_num : trap_num_q};
		if (take_trace) begin
			src_d = SRC_TRACE;
			vec_d = VEC_TRACE;
		end else if (take_irq) begin
			src_d = SRC_IRQ;
			vec_d = irq_vec_num;
		end
	end

	// ****
	// Trap held while a higher source is served
	// ****
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			trap_pend_q <= 1'b0;
			trap_num_q  <= 2'h0;
		end else if (clk_en) begin
			if (reset_go)
				trap_pend_q <= 1'b0;
			else if (trap_now && (take_trace || take_irq)) begin
				trap_pend_q <= 1'b1;
				trap_num_q  <= trap_num;
			end else if (accept && src_d == SRC_TRAP)
				trap_pend_q <= 1'b0;
		end
	end

	// ****
	// Reset kind
	// ****
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			manual_q <= 1'b0;
		else if (clk_en && (state_q == ST_HOLD || wdt_overflow))
			manual_q <= !nmi_in && manual_en;
	end

	// ****
	// Sequencer
	// ****
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q     <= ST_HOLD;
			src_q       <= SRC_RESET;
			vec_q       <= VEC_POWER_ON;
			push_cnt_q  <= 2'h0;
			push_need_q <= 2'h0;
		end else if (clk_en) begin
			if (!reset_in_n)
				state_q <= ST_HOLD;
			else if (reset_go) begin
				state_q     <= ST_MASK;
				src_q       <= SRC_RESET;
				push_need_q <= 2'h0;
				vec_q       <= (!nmi_in && manual_en) ?
				               VEC_MANUAL : VEC_POWER_ON;
			end else if (accept) begin
				state_q     <= ST_PUSH;
				src_q       <= src_d;
				vec_q       <= vec_d;
				push_cnt_q  <= 2'h0;
				push_need_q <= mode2 ? FRAME_MODE2 : FRAME_MODE0;
			end else begin
				unique case (state_q)
					ST_HOLD, ST_IDLE: ;
					ST_PUSH:
						if (mem_wr_ready) begin
							push_cnt_q <= push_cnt_q + 2'h1;
							if (push_cnt_q + 2'h1 == push_need_q)
								state_q <= ST_MASK;
						end
					ST_MASK: state_q <= ST_VEC;
					ST_VEC:  if (mem_rd_ready) state_q <= ST_JUMP;
					ST_JUMP: state_q <= ST_IDLE;
				endcase
			end
		end
	end

	// ****
	// Saved context and new flag values
	// ****
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pc_q          <= 24'h00_0000;
			cc_q          <= 8'h00;
			ec_q          <= 8'h00;
			sp_q          <= WORD_ZERO;
			cond_code_new <= 8'h00;
			ext_ctrl_new  <= 8'h00;
		end else if (clk_en) begin
			if (reset_go) begin
				cond_code_new        <= cond_code_cur;
				cond_code_new[I_BIT] <= 1'b1;
				ext_ctrl_new         <= {1'b0, ext_ctrl_cur[6:3], LEVEL_ALL};
			end else if (accept) begin
				// At a handling end the handler start is the resume point
				pc_q                 <= jump_bnd ? pc_load_val : pc_cur;
				sp_q                 <= jump_bnd ? sp_new : sp_cur;
				cc_q                 <= cond_code_cur;
				ec_q                 <= ext_ctrl_cur;
				cond_code_new        <= cond_code_cur;
				cond_code_new[I_BIT] <= 1'b1;
				ext_ctrl_new         <= ext_ctrl_cur;
				ext_ctrl_new[T_BIT]  <= 1'b0;
				if (mode2 && src_d == SRC_IRQ)
					ext_ctrl_new[2:0] <= irq_level;
			end else if (state_q == ST_PUSH && mem_wr_ready)
				sp_q <= mem_wr_addr;
		end
	end

	// ****
	// Stack, vector and jump outputs
	// ****
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sp_new      <= WORD_ZERO;
			pc_load_val <= 24'h00_0000;
		end else if (clk_en) begin
			if (state_q == ST_MASK && src_q != SRC_RESET)
				sp_new <= sp_q;
			if (state_q == ST_VEC && mem_rd_ready)
				pc_load_val <= mem_rd_data[23:0];
		end
	end

	assign cpu_hold     = state_q != ST_IDLE;
	assign flags_load   = state_q == ST_MASK;
	assign pc_load      = state_q == ST_JUMP;
	assign mem_wr_valid = state_q == ST_PUSH;
	assign mem_wr_addr  = sp_q - STACK_STEP;
	// Program counter and condition codes first, extended flags below
	assign mem_wr_data  = (push_cnt_q == 2'h0) ? {cc_q, pc_q} : {ec_q, 24'h00_0000};
	assign mem_rd_valid = state_q == ST_VEC;
	assign mem_rd_addr  = {22'h0, vec_q, VEC_SLOT_LO};

	// ****
	// Checks
	// ****
	prio_trace_a: assert property (@(posedge clk) disable iff (!nrst)
		take_trace && take_irq && !reset_go |=> src_q == SRC_TRACE)
		else $error("trace lost priority to interrupt");
	reset_start_a: assert property (@(posedge clk) disable iff (!nrst)
		clk_en && state_q == ST_HOLD && reset_in_n |=> state_q == ST_MASK)
		else $error("reset handling did not start");
	reset_kind_a: assert property (@(posedge clk) disable iff (!nrst)
		reset_go && reset_in_n && nmi_in |=> vec_q == VEC_POWER_ON)
		else $error("high nmi did not give power-on reset");
	trace_mode_a: assert property (@(posedge clk) disable iff (!nrst)
		!mode2 || return_from_exception |-> !take_trace)
		else $error("trace outside mode 2 or after return");
	irq_bound_a: assert property (@(posedge clk) disable iff (!nrst)
		irq_ack |-> irq_req && !(idle_bnd && ctrl_wr) && !(jump_bnd && src_q == SRC_RESET))
		else $error("interrupt taken where detection is skipped");
	trap_taken_a: assert property (@(posedge clk) disable iff (!nrst)
		trap_now && !reset_go && reset_in_n |=> state_q == ST_PUSH || trap_pend_q)
		else $error("trap instruction dropped");
	reset_push_a: assert property (@(posedge clk) disable iff (!nrst)
		src_q == SRC_RESET |-> !mem_wr_valid)
		else $error("reset pushed to stack");
	push_first_a: assert property (@(posedge clk) disable iff (!nrst)
		$rose(mem_rd_valid) && src_q != SRC_RESET |-> push_cnt_q == push_need_q)
		else $error("vector fetch before frame complete");
	mask_clear_a: assert property (@(posedge clk) disable iff (!nrst)
		flags_load |-> cond_code_new[I_BIT] && !ext_ctrl_new[T_BIT])
		else $error("mask not set or trace not cleared");
	vec_jump_a: assert property (@(posedge clk) disable iff (!nrst)
		clk_en && mem_rd_valid && mem_rd_ready && reset_in_n && !wdt_overflow
		|=> pc_load && pc_load_val == $past(mem_rd_data[23:0]))
		else $error("jump does not use fetched vector");
endmodule

// ===== design/ces_pkg.sv
// Constants and types of the exception sequencer.
// Assumes a 32-bit word memory port and a 24-bit program counter.
package ces_pkg;
	// ****
	// Sequencer states and sources
	// ****
	typedef enum {ST_HOLD, ST_IDLE, ST_PUSH, ST_MASK, ST_VEC, ST_JUMP} ces_state_type;
	typedef enum {SRC_RESET, SRC_TRACE, SRC_IRQ, SRC_TRAP} ces_src_type;
	// ****
	// Vector numbers and layout
	// ****
	localparam logic [7:0]  VEC_POWER_ON = 8'h00;
	localparam logic [7:0]  VEC_MANUAL   = 8'h01;
	localparam logic [7:0]  VEC_TRACE    = 8'h05;
	localparam logic [5:0]  VEC_TRAP_HI  = 6'h02;
	localparam logic [1:0]  VEC_SLOT_LO  = 2'h0;
	localparam logic [31:0] STACK_STEP   = 32'h0000_0004;
	localparam logic [1:0]  FRAME_MODE0  = 2'h1;
	localparam logic [1:0]  FRAME_MODE2  = 2'h2;
	// ****
	// Interrupt control modes and flag positions
	// ****
	localparam logic [1:0] MODE_0     = 2'h0;
	localparam logic [1:0] MODE_2     = 2'h2;
	localparam int         T_BIT      = 7;
	localparam int         I_BIT      = 7;
	localparam logic [2:0] LEVEL_ALL  = 3'h7;
	// ****
	// Register map
	// ****
	localparam logic [7:0]  REG_CTRL     = 8'h00;
	localparam logic [7:0]  REG_STATUS   = 8'h04;
	localparam logic [2:0]  CTRL_RESET   = 3'h0;
	localparam int          CTRL_MANUAL  = 2;
	localparam int          STS_BUSY     = 0;
	localparam int          STS_MANUAL   = 1;
	localparam int          STS_ILLEGAL  = 2;
	localparam int          STS_TRACE    = 3;
	localparam int          STS_VEC_LSB  = 8;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
	localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;

	function automatic logic ces_is_mode2(input logic [1:0] m);
		return m == MODE_2;
	endfunction

	function automatic logic ces_mode_legal(input logic [1:0] m);
		return (m == MODE_0) || (m == MODE_2);
	endfunction
endpackage

// ===== design/ces_regs.sv
// AXI4-Lite register slave of the exception sequencer.
// Assumes a single clock; one write and one read outstanding at a time.
`timescale 1ns/10ps
module ces_regs
	import ces_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        clk_en,
	// AXI4-Lite write
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Sequencer side
	input  wire logic        mode_clear,
	input  wire logic [31:0] status_in,
	output logic             irq_ctrl_mode_bit0,
	output logic             irq_ctrl_mode_bit1,
	output logic             manual_en
);
	logic [2:0]  ctrl_q;
	logic        aw_q, w_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic        wstrb0_q;

	assign s_axi_awready      = !aw_q;
	assign s_axi_wready       = !w_q;
	assign s_axi_arready      = !s_axi_rvalid;
	assign irq_ctrl_mode_bit0 = ctrl_q[0];
	assign irq_ctrl_mode_bit1 = ctrl_q[1];
	assign manual_en          = ctrl_q[CTRL_MANUAL];

	// ****
	// Write channel
	// ****
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			aw_q         <= 1'b0;
			w_q          <= 1'b0;
			awaddr_q     <= 8'h00;
			wdata_q      <= WORD_ZERO;
			wstrb0_q     <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
			ctrl_q       <= CTRL_RESET;
		end else if (clk_en) begin
			if (s_axi_awvalid && !aw_q) begin
				aw_q     <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_q) begin
				w_q      <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb0_q <= s_axi_wstrb[0];
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (aw_q && w_q && !s_axi_bvalid) begin
				aw_q         <= 1'b0;
				w_q          <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= RESP_OKAY;
				if (awaddr_q == REG_CTRL && wstrb0_q)
					ctrl_q <= wdata_q[2:0];
				else if (awaddr_q != REG_CTRL && awaddr_q != REG_STATUS)
					s_axi_bresp <= RESP_SLVERR;
			end
			// Reset handling forces mode 0 over any write
			if (mode_clear)
				ctrl_q[1:0] <= MODE_0;
		end
	end

	// ****
	// Read channel
	// ****
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= WORD_ZERO;
			s_axi_rresp  <= RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (s_axi_arvalid && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= RESP_OKAY;
				unique case (s_axi_araddr)
					REG_CTRL:   s_axi_rdata <= {29'h0, ctrl_q};
					REG_STATUS: s_axi_rdata <= status_in;
					default: begin
						s_axi_rdata <= WORD_ZERO;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end
		end
	end
endmodule

// ===== tb/ces_mem_model.sv
// Memory-side partner of the exception sequencer: stack and vector table.
// Assumes requests that hold valid and payload until ready is seen.
`timescale 1ns/10ps
module ces_mem_model (
	// Clock and pacing
	input  wire logic        clk,
	input  wire logic        slow,
	// Stack push
	input  wire logic        mem_wr_valid,
	output logic             mem_wr_ready,
	input  wire logic [31:0] mem_wr_addr,
	input  wire logic [31:0] mem_wr_data,
	// Vector fetch
	input  wire logic        mem_rd_valid,
	output logic             mem_rd_ready,
	input  wire logic [31:0] mem_rd_addr,
	output logic [31:0]      mem_rd_data,
	// Observation
	output int               wr_cnt,
	output logic [31:0]      last_wr_addr,
	output logic [31:0]      last_rd_addr,
	output logic [31:0]      last_wr_data,
	output logic             order_err
);
	int	wait_q = 0;
	logic	[31:0] vec_word;

	// Slow pacing stalls every word for three cycles
	assign mem_wr_ready = mem_wr_valid && (wait_q >= (slow ? 3 : 0));
	assign mem_rd_ready = mem_rd_valid && (wait_q >= (slow ? 3 : 0));
	// Each slot holds its own handler address; idle data is scrambled
	assign vec_word = 32'h00C0_0000 | mem_rd_addr;
	assign mem_rd_data = mem_rd_ready ? vec_word : ~vec_word;

	initial begin
		wr_cnt = 0;
		order_err = 1'b0;
	end

	always @(posedge clk) begin
		if ((mem_wr_valid && mem_wr_ready) || (mem_rd_valid && mem_rd_ready))
			wait_q <= 0;
		else if (mem_wr_valid || mem_rd_valid)
			wait_q <= wait_q + 1;
		if (mem_wr_valid && mem_wr_ready) begin
			wr_cnt <= wr_cnt + 1;
			last_wr_addr <= mem_wr_addr;
			last_wr_data <= mem_wr_data;
		end
		if (mem_rd_valid && mem_rd_ready)
			last_rd_addr <= mem_rd_addr;
		if (mem_wr_valid && mem_rd_valid)
			order_err <= 1'b1;
	end
endmodule

// ===== tb/ces_sequencer_tb_top.sv
// Self-checking bench of the exception sequencer.
// Assumes the memory partner model and a 40 MHz clock.
`timescale 1ns/10ps
module ces_sequencer_tb_top
	import ces_pkg::*;
;
	localparam logic [31:0] NONE = 32'hFFFF_FFFF;
	localparam logic [31:0] SP = 32'h0000_FF00;
	logic	clk, nrst, clk_en, slow, cpu_hold, pc_load, flags_load, irq_req, irq_ack;
	logic	s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic	s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic	[7:0] s_axi_awaddr, s_axi_araddr, qual, irq_vec_num;
	logic	[3:0] s_axi_wstrb;
	logic	[1:0] s_axi_bresp, s_axi_rresp, trap_num;
	logic	[31:0] s_axi_wdata, s_axi_rdata, sp_cur, sp_new;
	logic	reset_in_n, wdt_overflow, nmi_in, insn_done, return_from_exception;
	logic	and_into_control, or_into_control, xor_into_control, load_control, trap_instruction;
	logic	[23:0] pc_cur, pc_load_val, pc_seen;
	logic	[7:0] cond_code_cur, ext_ctrl_cur, cond_code_new, ext_ctrl_new, cc_seen, ext_seen;
	logic	[2:0] irq_level;
	logic	mem_wr_valid, mem_wr_ready, mem_rd_valid, mem_rd_ready, order_err;
	logic	[31:0] mem_wr_addr, mem_wr_data, mem_rd_addr, mem_rd_data;
	logic	[31:0] last_wr_addr, last_wr_data, last_rd_addr;
	int	fails, checked, pl_cnt, wr0, cyc, wr_cnt;

	assign {trap_num, trap_instruction, load_control, xor_into_control, or_into_control,
		and_into_control, return_from_exception} = qual;

	ces_sequencer i_dut (
		.clk, .nrst, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .reset_in_n, .wdt_overflow, .nmi_in, .insn_done,
		.return_from_exception, .and_into_control, .or_into_control, .xor_into_control,
		.load_control, .trap_instruction, .trap_num, .pc_cur, .cond_code_cur, .ext_ctrl_cur,
		.sp_cur, .cpu_hold, .pc_load, .pc_load_val, .flags_load, .cond_code_new, .ext_ctrl_new,
		.sp_new, .irq_req, .irq_vec_num, .irq_level, .irq_ack, .mem_wr_valid, .mem_wr_ready,
		.mem_wr_addr, .mem_wr_data, .mem_rd_valid, .mem_rd_ready, .mem_rd_addr, .mem_rd_data
	);

	ces_mem_model i_mem (
		.clk, .slow, .mem_wr_valid, .mem_wr_ready, .mem_wr_addr, .mem_wr_data, .mem_rd_valid,
		.mem_rd_ready, .mem_rd_addr, .mem_rd_data, .wr_cnt, .last_wr_addr, .last_rd_addr,
		.last_wr_data, .order_err
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ****
	// Monitors, timeout and shared tasks
	// ****
	always @(negedge clk) begin
		if (pc_load === 1'b1) begin
			pl_cnt++;
			pc_seen = pc_load_val;
		end
		if (flags_load === 1'b1) begin
			cc_seen = cond_code_new;
			ext_seen = ext_ctrl_new;
		end
	end

	always @(posedge clk) begin
		cyc++;
		if (irq_ack === 1'b1)
			irq_req <= 1'b0;
		if (cyc == 5000) begin
			fails++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// One completing instruction with its qualifiers
	task automatic boundary(input logic [7:0] q, input logic irq, input logic ack);
		@(posedge clk);
		insn_done <= 1'b1;
		irq_req <= irq;
		qual <= q;
		@(negedge clk);
		chk("irq_ack", {31'h0, irq_ack}, {31'h0, ack});
		@(posedge clk);
		insn_done <= 1'b0;
		qual <= 8'h00;
	endtask

	// Waits for the next handler start, or proves that none comes
	task automatic expect_entry(input logic [31:0] va, input int nw, input logic [31:0] wa,
		input logic [31:0] wd);
		int p0 = pl_cnt;
		for (int n = 0; n < 60 && pl_cnt == p0; n++)
			@(negedge clk);
		if (va === NONE)
			chk("no_entry", pl_cnt - p0, 32'h0);
		else begin
			chk("vec_addr", last_rd_addr, va);
			chk("new_pc", {8'h00, pc_seen}, 32'h00C0_0000 | va);
			chk("pushes", wr_cnt - wr0, nw);
			if (nw > 0) begin
				chk("push_addr", last_wr_addr, wa);
				chk("push_data", last_wr_data, wd);
			end
		end
		wr0 = wr_cnt;
	endtask

	// ****
	// Scenarios
	// ****
	task automatic t_reset_irq();
		logic [31:0] d;
		logic [1:0] r;
		expect_entry(32'h0, 0, 32'h0, 32'h0);
		chk("rst_flags", {cc_seen[I_BIT], ext_seen[T_BIT], ext_seen[2:0]}, 5'h17);
		expect_entry(NONE, 0, 32'h0, 32'h0);
		for (int i = 1; i < 5; i++) begin
			boundary(8'h01 << i, 1'b1, 1'b0);
			expect_entry(NONE, 0, 32'h0, 32'h0);
		end
		boundary(8'h00, 1'b1, 1'b1);
		expect_entry(32'h40, 1, SP - 32'h4, {cond_code_cur, pc_cur});
		axi_rd(REG_CTRL, d, r);
		chk("mode_after_reset", {30'h0, d[1:0]}, 32'h0);
	endtask

	task automatic t_traps();
		for (int n = 0; n < 4; n++) begin
			slow <= n[0];
			boundary({n[1:0], 6'h20}, 1'b0, 1'b0);
			expect_entry(32'h20 + 32'(n) * 32'h4, 1, SP - 32'h4, {cond_code_cur, pc_cur});
			chk("trap_mask", {31'h0, cc_seen[I_BIT]}, 32'h1);
			chk("sp_new", sp_new, SP - 32'h4);
		end
	endtask

	task automatic t_mode2();
		logic [31:0] d;
		logic [1:0] r;
		axi_wr(REG_CTRL, 32'h2, r);
		ext_ctrl_cur <= 8'h83;
		boundary(8'h01, 1'b0, 1'b0);
		expect_entry(NONE, 0, 32'h0, 32'h0);
		boundary(8'h20, 1'b1, 1'b0);
		expect_entry(32'h14, 2, SP - 32'h8, 32'h8300_0000);
		chk("trace_clear", {31'h0, ext_seen[T_BIT]}, 32'h0);
		// Chained frames nest below the frame just written
		expect_entry(32'h40, 2, SP - 32'h10, 32'h8300_0000);
		chk("irq_level", {29'h0, ext_seen[2:0]}, 32'h5);
		expect_entry(32'h20, 2, SP - 32'h18, 32'h8300_0000);
		axi_wr(REG_CTRL, 32'h1, r);
		axi_rd(REG_STATUS, d, r);
		chk("illegal_flag", {31'h0, d[STS_ILLEGAL]}, 32'h1);
		boundary(8'h20, 1'b0, 1'b0);
		expect_entry(32'h20, 1, SP - 32'h4, {cond_code_cur, pc_cur});
		axi_wr(8'h40, 32'h7, r);
		chk("unmapped_wr", {30'h0, r}, {30'h0, RESP_SLVERR});
		axi_rd(8'h40, d, r);
		chk("unmapped_rd", {d[29:0], r}, {30'h0, RESP_SLVERR});
	endtask

	task automatic t_resets();
		logic [31:0] d;
		logic [1:0] r;
		axi_wr(REG_CTRL, 32'h2, r);
		wdt_overflow <= 1'b1;
		@(posedge clk);
		wdt_overflow <= 1'b0;
		expect_entry(32'h0, 0, 32'h0, 32'h0);
		axi_rd(REG_CTRL, d, r);
		chk("mode_cleared", {30'h0, d[1:0]}, 32'h0);
		axi_wr(REG_CTRL, 32'h4, r);
		for (int k = 0; k < 2; k++) begin
			nmi_in <= k[0];
			reset_in_n <= 1'b0;
			repeat (3) @(posedge clk);
			chk("hold", {31'h0, cpu_hold}, 32'h1);
			reset_in_n <= 1'b1;
			expect_entry(k ? 32'h0 : 32'h4, 0, 32'h0, 32'h0);
			axi_rd(REG_STATUS, d, r);
			chk("status", {23'h0, d[15:8], d[STS_MANUAL]}, k ? 32'h0 : 32'h3);
		end
		// Frozen clock enable must ignore an instruction end
		clk_en <= 1'b0;
		boundary(8'h20, 1'b0, 1'b0);
		expect_entry(NONE, 0, 32'h0, 32'h0);
		clk_en <= 1'b1;
	endtask

	// ****
	// Main sequence
	// ****
	initial begin
		{nrst, slow, insn_done, wdt_overflow, qual, fails, checked, pl_cnt, wr0, cyc} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{clk_en, reset_in_n, nmi_in, irq_req} = 4'hF;
		s_axi_wstrb = 4'hF;
		{pc_cur, cond_code_cur, ext_ctrl_cur, sp_cur} = {24'h12_3456, 8'h05, 8'h03, SP};
		{irq_vec_num, irq_level} = {8'h10, 3'h5};
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		t_reset_irq();
		t_traps();
		t_mode2();
		t_resets();
		chk("stack_before_fetch", {31'h0, order_err}, 32'h0);
		end_sim();
	end
endmodule
